// ### pc_card_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pc_card_checker (
  input wire logic       i_ref_clk,
  input wire logic       i_reset,
  input wire logic [9:0] host_addr_bus,
  input wire logic       card_data_oe,
  input wire logic       card_enable_low_n,
  input wire logic       card_enable_high_n,
  input wire logic       register_space_sel_n,
  input wire logic       attr_read_strobe_n,
  input wire logic       attr_write_strobe_n,
  input wire logic       io_read_strobe_n,
  input wire logic       io_write_strobe_n,
  input wire logic       io_read_ack_n,
  input wire logic       host_wait_n
);
  // One clock domain, so clocking and reset are declared once for all properties.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  // Any host strobe falling, and a read cycle that starts a wait.
  sequence strobe_start;
    $fell(io_read_strobe_n && io_write_strobe_n && attr_read_strobe_n && attr_write_strobe_n);
  endsequence
  sequence read_wait_start;
    $fell(host_wait_n) && !io_read_strobe_n;
  endsequence

  // The wait may not appear before the strobe has crossed both synchroniser stages.
  sync_delay_a: assert property (strobe_start |-> host_wait_n [*2])
    else $error("Wait asserted before the strobe was synchronised.");
  write_wait_a: assert property ($fell(host_wait_n) && !io_write_strobe_n |=> host_wait_n)
    else $error("Write wait lasted longer than one cycle.");
  read_sync_wait_a: assert property ($fell(io_read_ack_n) |-> !host_wait_n)
    else $error("Valid read acknowledged without a wait.");
  read_wait_end_a: assert property (read_wait_start |-> ##[1:40] $rose(host_wait_n))
    else $error("Read wait never released.");
  wait_needs_sel_a: assert property ($fell(host_wait_n) |-> $past(!register_space_sel_n, 3))
    else $error("Wait started for a cycle without register select.");
  ack_cause_a: assert property ($fell(io_read_ack_n) |-> $past(!io_read_strobe_n &&
    !card_enable_low_n && !card_enable_high_n && !register_space_sel_n, 2))
    else $error("Acknowledge without a valid read.");
  ack_holds_a: assert property (!io_read_ack_n && !io_read_strobe_n |=> !io_read_ack_n)
    else $error("Acknowledge dropped during the read strobe.");
  data_first_a: assert property ($rose(host_wait_n) && !(io_read_strobe_n && attr_read_strobe_n)
    |-> card_data_oe && $past(card_data_oe))
    else $error("Wait released before read data was driven.");
  attr_even_a: assert property ($fell(host_wait_n) && !(attr_read_strobe_n && attr_write_strobe_n)
    |-> !host_addr_bus[0])
    else $error("Attribute access served at an odd byte.");
  data_cause_a: assert property ($rose(card_data_oe) |-> !(io_read_strobe_n && attr_read_strobe_n))
    else $error("Card drove data outside a read.");
  strobe_excl_a: assert property (!(io_read_strobe_n && io_write_strobe_n)
    |-> attr_read_strobe_n && attr_write_strobe_n)
    else $error("Memory strobe used during an I/O cycle.");
endmodule : pc_card_checker
`default_nettype wire

// ### pc_card_host_port.sv
`include "pc_card_map.svh"
`timescale 1ns/1ns
`default_nettype none
module pc_card_host_port #(
  parameter int IO_SPAN = 64
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  pc_card_if.card          bus,
  input  wire logic        i_io_mode,
  input  wire logic        i_cis_ready,
  input  wire logic        i_irq,
  input  wire logic [3:0]  i_io_addr_mask,
  input  wire logic [3:0]  i_io_addr_match,
  output logic             o_core_req,
  output logic             o_core_we,
  output logic             o_core_attr,
  output logic [8:0]       o_core_addr,
  output logic [1:0]       o_core_be,
  output pc_card_pkg::word_t o_core_wdata,
  input  wire logic        i_core_ack,
  input  wire pc_card_pkg::word_t i_core_rdata
);
  import pc_card_pkg::*;

  // The decode below serves exactly six register address bits.
  // A wider span would need a wider offset.
  if (IO_SPAN != (1 << `IO_ADDR_W)) begin : g_span_check
    $error("IO_SPAN must equal 64");
  end

  // All state is one struct: q the flops, d their next value.
  // One struct makes every reset value explicit.
  dev_s q;
  dev_s d;
  logic [6:0] c;
  logic [9:0] a;
  logic       ce_any;
  logic       cel_odd;
  logic       mask_ok;
  logic       io_rd_v;
  logic       io_wr_v;
  logic       at_v;
  logic       strobe_any;
  logic       newc;
  logic [1:0] lanes;

  // Decode of the synchronised cycle; the first stage is never read here.
  always_comb begin
    c = q.ctl_s2;
    a = q.adr_s2;
    // Either enable low means the card is addressed.
    ce_any = c[`CTL_CEL] | c[`CTL_CEH];
    // The low enable alone with bit 0 set is the odd byte.
    cel_odd = c[`CTL_CEL] & ~c[`CTL_CEH] & a[0];
    // A zero mask bit disregards that upper address bit.
    mask_ok = (((a[9:6] ^ i_io_addr_match) & i_io_addr_mask) == `MASK_DEFAULT);
    // I/O strobes count only in I/O mode and with register select.
    // A miss on the masked upper bits ignores the cycle.
    io_rd_v = i_io_mode & c[`CTL_REG] & ce_any & c[`CTL_IORD] & mask_ok;
    io_wr_v = i_io_mode & c[`CTL_REG] & ce_any & c[`CTL_IOWR] & mask_ok;
    // Odd attribute bytes do not exist, so such a cycle is not taken.
    at_v = c[`CTL_REG] & c[`CTL_CEL] & ~a[0] & (c[`CTL_ATRD] ^ c[`CTL_ATWR]);
    strobe_any = c[`CTL_ATRD] | c[`CTL_ATWR] | c[`CTL_IORD] | c[`CTL_IOWR];
    // The taken flag stops a long strobe from starting twice.
    newc = (io_rd_v | io_wr_v | at_v) & ~q.taken;
    // Both enables give a word, one enable a single byte lane.
    if (c[`CTL_CEL] & c[`CTL_CEH]) begin
      lanes = 2'h3;
    end else if (cel_odd | ~c[`CTL_CEL]) begin
      lanes = 2'h2;
    end else begin
      lanes = 2'h1;
    end
  end

  // Next-state logic for the whole port.
  always_comb begin
    d = q;
    // Every pin passes two flops before the decode sees it.
    d.ctl_s1 = ~{bus.io_write_strobe_n, bus.io_read_strobe_n, bus.attr_write_strobe_n,
                 bus.attr_read_strobe_n, bus.register_space_sel_n,
                 bus.card_enable_high_n, bus.card_enable_low_n};
    d.ctl_s2 = q.ctl_s1;
    // Address and data take the same two stages as the strobes.
    d.adr_s1 = bus.host_addr_bus;
    d.adr_s2 = q.adr_s1;
    d.dat_s1 = bus.host_data_bus;
    d.dat_s2 = q.dat_s1;
    // Taken clears only when every strobe is high again.
    d.taken = q.taken & strobe_any;
    // The acknowledge follows the valid read for as long as the strobe lasts.
    // Built from synchronised pins, it trails the strobe by three cycles.
    // It follows only a valid read, so both enables are needed.
    d.ack_n = ~(io_rd_v & c[`CTL_CEL] & c[`CTL_CEH]);
    // Ready flag until I/O mode, then a level interrupt, active low.
    d.irq_n = i_io_mode ? ~i_irq : i_cis_ready;
    // Idle, read in flight, read data shown, write posted.
    unique case (q.st)
      DEV_IDLE: begin
        // A refused cycle never leaves idle and never waits.
        d.wait_n = 1'b1;
        if (newc) begin
          // The core request stands until the core acknowledges it.
          d.taken = 1'b1;
          d.req = 1'b1;
          d.wait_n = 1'b0;
          d.we = io_wr_v | c[`CTL_ATWR];
          d.attr = at_v;
          d.rd_odd = cel_odd;
          // Attribute bytes are even, so bit 0 is dropped.
          // I/O offsets are folded to even word addresses.
          if (at_v) begin
            d.caddr = a[9:1];
            d.be = 2'h1;
          end else begin
            d.caddr = {3'h0, a[`IO_ADDR_W-1:1], 1'b0};
            d.be = lanes;
          end
          // A lone byte on the low lane at an odd address belongs to the high lane.
          d.wdata = cel_odd ? {q.dat_s2[7:0], q.dat_s2[7:0]} : q.dat_s2;
          // Writes are posted, so the host sees only the sync wait.
          d.st = (io_wr_v | c[`CTL_ATWR]) ? DEV_POST : DEV_ACCESS;
        end
      end
      DEV_ACCESS: begin
        // Wait stays low until the core answers the read.
        if (i_core_ack) begin
          d.req = 1'b0;
          // An odd byte read returns the upper byte on the low lane.
          d.rdata = q.rd_odd ? {i_core_rdata[15:8], i_core_rdata[15:8]} : i_core_rdata;
          // Data goes out now; wait is released one cycle later.
          d.dat_oe = 1'b1;
          d.st = DEV_PRESENT;
        end
      end
      DEV_PRESENT: begin
        // Data went out one cycle before wait is released.
        d.wait_n = 1'b1;
        // Data stays on the bus until the host releases its strobe.
        // Leaving early would let the bus float mid-read.
        if (!strobe_any) begin
          d.dat_oe = 1'b0;
          d.st = DEV_IDLE;
        end
      end
      DEV_POST: begin
        // The write is latched; only a later access is stalled.
        // A new cycle arriving now is stalled until the write is done.
        d.wait_n = ~newc;
        // The core write has finished once its acknowledge arrives.
        if (i_core_ack) begin
          d.req = 1'b0;
          d.st = DEV_IDLE;
        end
      end
    endcase
  end

  // State register; reset parks every pin at its idle level.
  // The reset is asynchronous so the pins idle before the clock runs.
  // The request pin starts low: busy until the table is ready.
  // Only constants are assigned while reset is high.
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
      q.st <= DEV_IDLE;
      q.wait_n <= 1'b1;
      q.ack_n <= 1'b1;
      q.irq_n <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Every output comes straight from a flop, so none can glitch.
  // The data enable is high only while the card drives the bus.
  assign bus.card_data_out = q.rdata;
  assign bus.card_data_oe = q.dat_oe;
  assign bus.io_read_ack_n = q.ack_n;
  assign bus.host_wait_n = q.wait_n;
  assign bus.host_request_n = q.irq_n;
  assign o_core_req = q.req;
  assign o_core_we = q.we;
  assign o_core_attr = q.attr;
  assign o_core_addr = q.caddr;
  assign o_core_be = q.be;
  assign o_core_wdata = q.wdata;
endmodule : pc_card_host_port
`default_nettype wire

// ### pc_card_if.sv
`timescale 1ns/1ns
`default_nettype none
// Socket wiring between the controller and the card; pull-ups idle the data lines high.
interface pc_card_if;
  logic [9:0]  host_addr_bus;
  logic [15:0] host_data_to_card;
  logic        host_data_oe;
  logic [15:0] card_data_out;
  logic        card_data_oe;
  logic [15:0] host_data_bus;
  logic        card_enable_low_n;
  logic        card_enable_high_n;
  logic        attr_read_strobe_n;
  logic        attr_write_strobe_n;
  logic        io_read_strobe_n;
  logic        io_write_strobe_n;
  logic        register_space_sel_n;
  logic        io_read_ack_n;
  logic        host_wait_n;
  logic        host_request_n;

  // Resolved data wire; an undriven bus floats high on its pull-ups.
  assign host_data_bus = card_data_oe ? card_data_out :
                         (host_data_oe ? host_data_to_card : 16'hffff);

  modport host (output host_addr_bus, host_data_to_card, host_data_oe, card_enable_low_n,
                card_enable_high_n, attr_read_strobe_n, attr_write_strobe_n,
                io_read_strobe_n, io_write_strobe_n, register_space_sel_n,
                input host_data_bus, io_read_ack_n, host_wait_n, host_request_n);
  modport card (input host_addr_bus, host_data_bus, card_enable_low_n, card_enable_high_n,
                attr_read_strobe_n, attr_write_strobe_n, io_read_strobe_n,
                io_write_strobe_n, register_space_sel_n,
                output card_data_out, card_data_oe, io_read_ack_n, host_wait_n,
                host_request_n);
endinterface : pc_card_if
`default_nettype wire

// ### pc_card_map.svh
`ifndef PC_CARD_MAP_SVH
`define PC_CARD_MAP_SVH
// Control pin positions after synchronisation, all active high inside.
`define CTL_CEL   0
`define CTL_CEH   1
`define CTL_REG   2
`define CTL_ATRD  3
`define CTL_ATWR  4
`define CTL_IORD  5
`define CTL_IOWR  6
`define CTL_W     7
// Decode widths and the address mask default that ignores the upper bits.
`define IO_ADDR_W     6
`define MASK_DEFAULT  4'h0
// Host cycle timing in ns and derived cycle counts.
`define CLK_PERIOD_NS     10
`define T_ADDR_SETUP_NS   70
`define T_STROBE_WIDTH_NS 165
`define T_ADDR_HOLD_NS    20
`define CYC_SETUP ((`T_ADDR_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_WIDTH ((`T_STROBE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_HOLD  ((`T_ADDR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Controller register offsets.
`define REG_ADDR   8'h00
`define REG_WDATA  8'h04
`define REG_CMD    8'h08
`define REG_STATUS 8'h0c
`define REG_RDATA  8'h10
`define REG_CTRL   8'h14
// Status bit positions.
`define ST_BUSY    0
`define ST_DONE    1
`define ST_REFUSED 2
`define ST_REQ     3
`define ST_ACK     4
// Command kinds in bits 1:0, lanes in bits 3:2.
`define CMD_IORD   2'h0
`define CMD_IOWR   2'h1
`define CMD_ATRD   2'h2
`define CMD_ATWR   2'h3
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// ### pc_card_pkg.sv
`include "pc_card_map.svh"
`default_nettype none
package pc_card_pkg;
  typedef enum logic [1:0] {DEV_IDLE, DEV_ACCESS, DEV_PRESENT, DEV_POST} dev_state_e;
  typedef enum logic [1:0] {HST_IDLE, HST_SETUP, HST_STROBE, HST_HOLD} hst_state_e;
  typedef logic [15:0] word_t;

  typedef struct packed {
    dev_state_e  st;
    logic [6:0]  ctl_s1;
    logic [6:0]  ctl_s2;
    logic [9:0]  adr_s1;
    logic [9:0]  adr_s2;
    word_t       dat_s1;
    word_t       dat_s2;
    logic        taken;
    logic        req;
    logic        we;
    logic        attr;
    logic [8:0]  caddr;
    logic [1:0]  be;
    word_t       wdata;
    word_t       rdata;
    logic        rd_odd;
    logic        dat_oe;
    logic        wait_n;
    logic        ack_n;
    logic        irq_n;
  } dev_s;

  typedef struct packed {
    hst_state_e  st;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_adr;
    logic [31:0] w_dat;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [9:0]  addr_r;
    word_t       wdat_r;
    logic [3:0]  cmd_r;
    logic        io_en;
    logic        done;
    logic        refused;
    logic        ack_seen;
    word_t       rdat_r;
    logic [4:0]  cnt;
    logic [2:0]  sy1;
    logic [2:0]  sy2;
    word_t       din_s1;
    word_t       din_s2;
    logic [9:0]  a;
    word_t       d;
    logic        doe;
    logic [`CTL_W-1:0] ctl_n;
  } hst_s;
endpackage : pc_card_pkg
`default_nettype wire

// ### pc_card_socket_ctrl.sv
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`include "pc_card_map.svh"
`timescale 1ns/1ns
`default_nettype none
module pc_card_socket_ctrl #(
  parameter int SETUP_CYC = `CYC_SETUP,
  parameter int WIDTH_CYC = `CYC_WIDTH,
  parameter int HOLD_CYC  = `CYC_HOLD
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  pc_card_if.host          bus,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);
  import pc_card_pkg::*;

  // The card's wait shows after three cycles plus two sync stages.
  if (SETUP_CYC < 1 || WIDTH_CYC < 5 || HOLD_CYC < 1 || SETUP_CYC > 31 || WIDTH_CYC > 31
      || HOLD_CYC > 31) begin : g_cnt_check
    $error("cycle counts must lie in 1..31, strobe width at least 5");
  end

  hst_s q;
  hst_s d;
  logic       wr_go;
  logic [1:0] kind;
  logic       bad;

  always_comb begin
    d = q;
    kind = q.cmd_r[1:0];
    d.sy1 = {bus.host_request_n, bus.io_read_ack_n, bus.host_wait_n};
    d.sy2 = q.sy1;
    d.din_s1 = bus.host_data_bus;
    d.din_s2 = q.din_s1;
    // Address and data may arrive in either order; the response follows both.
    if (i_awvalid & ~q.aw_got) begin
      d.aw_got = 1'b1;
      d.aw_adr = i_awaddr;
    end
    if (i_wvalid & ~q.w_got) begin
      d.w_got = 1'b1;
      d.w_dat = i_wdata;
    end
    if (q.bvalid & i_bready) begin
      d.bvalid = 1'b0;
    end
    wr_go = q.aw_got & q.w_got & ~q.bvalid;
    bad = 1'b0;
    if (wr_go) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `RESP_OKAY;
      unique case (q.aw_adr)
        `REG_ADDR:   d.addr_r = q.w_dat[9:0];
        `REG_WDATA:  d.wdat_r = q.w_dat[15:0];
        `REG_CTRL:   d.io_en = q.w_dat[0];
        `REG_STATUS: begin
          d.done = q.done & ~q.w_dat[`ST_DONE];
          d.refused = q.refused & ~q.w_dat[`ST_REFUSED];
        end
        `REG_CMD: begin
          d.cmd_r = q.w_dat[3:0];
          // Refuse I/O before enable, odd attribute bytes and busy starts.
          bad = (q.st != HST_IDLE) | (q.w_dat[3:2] == 2'h0)
                | (~q.w_dat[1] & ~q.io_en)
                | (q.w_dat[1] & q.addr_r[0]);
          if (bad) begin
            d.refused = 1'b1;
          end else begin
            d.st = HST_SETUP;
            d.cnt = 5'(SETUP_CYC);
            d.ack_seen = 1'b0;
            d.a = q.addr_r;
            d.d = q.wdat_r;
            d.doe = q.w_dat[0];
            // Lanes pick the enables; register select goes with every cycle.
            d.ctl_n[`CTL_CEL] = ~q.w_dat[2];
            d.ctl_n[`CTL_CEH] = ~q.w_dat[3];
            d.ctl_n[`CTL_REG] = 1'b0;
          end
        end
        default: d.bresp = `RESP_SLVERR;
      endcase
    end
    if (q.rvalid & i_rready) begin
      d.rvalid = 1'b0;
    end
    if (i_arvalid & ~q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = `RESP_OKAY;
      unique case (i_araddr)
        `REG_ADDR:   d.rdata = {22'h0, q.addr_r};
        `REG_WDATA:  d.rdata = {16'h0, q.wdat_r};
        `REG_CMD:    d.rdata = {28'h0, q.cmd_r};
        `REG_RDATA:  d.rdata = {16'h0, q.rdat_r};
        `REG_CTRL:   d.rdata = {31'h0, q.io_en};
        `REG_STATUS: d.rdata = {27'h0, q.ack_seen, q.sy2[2], q.refused, q.done,
                                q.st != HST_IDLE};
        default: begin
          d.rdata = 32'h0;
          d.rresp = `RESP_SLVERR;
        end
      endcase
    end
    // Pin sequencer: address setup, strobe with wait, then hold.
    if (q.cnt != 5'h0) begin
      d.cnt = q.cnt - 5'h1;
    end
    unique case (q.st)
      HST_IDLE: ;
      HST_SETUP: begin
        if (q.cnt == 5'h0) begin
          d.ctl_n[`CTL_IORD] = ~(kind == `CMD_IORD);
          d.ctl_n[`CTL_IOWR] = ~(kind == `CMD_IOWR);
          d.ctl_n[`CTL_ATRD] = ~(kind == `CMD_ATRD);
          d.ctl_n[`CTL_ATWR] = ~(kind == `CMD_ATWR);
          d.cnt = 5'(WIDTH_CYC);
          d.st = HST_STROBE;
        end
      end
      HST_STROBE: begin
        if (~q.sy2[1]) begin
          d.ack_seen = 1'b1;
        end
        // The card's wait is honoured only once the least width has passed.
        if (q.cnt == 5'h0 && q.sy2[0]) begin
          d.rdat_r = q.din_s2;
          d.ctl_n[`CTL_W-1:`CTL_ATRD] = 4'hf;
          d.cnt = 5'(HOLD_CYC);
          d.st = HST_HOLD;
        end
      end
      HST_HOLD: begin
        if (q.cnt == 5'h0) begin
          d.doe = 1'b0;
          d.ctl_n = '1;
          d.done = 1'b1;
          d.st = HST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '0;
      q.st <= HST_IDLE;
      q.ctl_n <= '1;
      q.sy1 <= 3'h7;
      q.sy2 <= 3'h7;
    end else begin
      q <= d;
    end
  end

  assign bus.host_addr_bus = q.a;
  assign bus.host_data_to_card = q.d;
  assign bus.host_data_oe = q.doe;
  assign bus.card_enable_low_n = q.ctl_n[`CTL_CEL];
  assign bus.card_enable_high_n = q.ctl_n[`CTL_CEH];
  assign bus.register_space_sel_n = q.ctl_n[`CTL_REG];
  assign bus.attr_read_strobe_n = q.ctl_n[`CTL_ATRD];
  assign bus.attr_write_strobe_n = q.ctl_n[`CTL_ATWR];
  assign bus.io_read_strobe_n = q.ctl_n[`CTL_IORD];
  assign bus.io_write_strobe_n = q.ctl_n[`CTL_IOWR];
  assign o_awready = ~q.aw_got;
  assign o_wready = ~q.w_got;
  assign o_bvalid = q.bvalid;
  assign o_bresp = q.bresp;
  assign o_arready = ~q.rvalid;
  assign o_rvalid = q.rvalid;
  assign o_rdata = q.rdata;
  assign o_rresp = q.rresp;
endmodule : pc_card_socket_ctrl
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pc_card_map.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import pc_card_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        io_mode = 1'b0, cis_ready = 1'b0, irq = 1'b0;
  logic [3:0]  mask = 4'h0, match = 4'h0;
  logic        core_req, core_we, core_attr, core_ack = 1'b0;
  logic [8:0]  core_addr, cap_addr;
  logic [1:0]  core_be, cap_be, bresp, rresp;
  word_t       core_wdata, core_rdata = 16'h0, cap_wdata;
  word_t       mem [0:511];
  logic        cap_we, cap_attr;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  int          error_cnt = 0, n_tests = 0, req_cnt = 0;

  pc_card_if sock ();
  pc_card_socket_ctrl #(.SETUP_CYC(1), .WIDTH_CYC(5), .HOLD_CYC(1)) i_pc_card_socket_ctrl (
    .i_ref_clk(clk), .i_reset(rst), .bus(sock),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready));
  pc_card_host_port i_pc_card_host_port (
    .i_ref_clk(clk), .i_reset(rst), .bus(sock), .i_io_mode(io_mode),
    .i_cis_ready(cis_ready), .i_irq(irq), .i_io_addr_mask(mask), .i_io_addr_match(match),
    .o_core_req(core_req), .o_core_we(core_we), .o_core_attr(core_attr),
    .o_core_addr(core_addr), .o_core_be(core_be), .o_core_wdata(core_wdata),
    .i_core_ack(core_ack), .i_core_rdata(core_rdata));
  pc_card_checker i_pc_card_checker (
    .i_ref_clk(clk), .i_reset(rst), .host_addr_bus(sock.host_addr_bus),
    .card_data_oe(sock.card_data_oe), .card_enable_low_n(sock.card_enable_low_n),
    .card_enable_high_n(sock.card_enable_high_n),
    .register_space_sel_n(sock.register_space_sel_n),
    .attr_read_strobe_n(sock.attr_read_strobe_n),
    .attr_write_strobe_n(sock.attr_write_strobe_n),
    .io_read_strobe_n(sock.io_read_strobe_n), .io_write_strobe_n(sock.io_write_strobe_n),
    .io_read_ack_n(sock.io_read_ack_n), .host_wait_n(sock.host_wait_n));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // Core memory answering each request with a one-cycle ack; taken requests are logged.
  always @(posedge clk) begin
    core_ack <= core_req && !core_ack && !rst;
    if (core_req && !core_ack) core_rdata <= mem[core_addr];
    if (core_req && core_ack) begin
      {cap_addr, cap_be, cap_we, cap_attr, cap_wdata} <= {core_addr, core_be, core_we,
                                                          core_attr, core_wdata};
      req_cnt <= req_cnt + 1;
      if (core_we && core_be[0]) mem[core_addr][7:0] <= core_wdata[7:0];
      if (core_we && core_be[1]) mem[core_addr][15:8] <= core_wdata[15:8];
    end
  end

  task give_verdict();
    if (error_cnt == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Write address and data are offered together; each drops at its own handshake.
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 100) begin error_cnt++; give_verdict(); end
    r = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 100) begin error_cnt++; give_verdict(); end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // One socket cycle through the controller registers, polled until it ends.
  task host_op(input logic [9:0] a, input word_t d, input logic [3:0] cmd,
               output logic [31:0] st, output logic [31:0] rd);
    logic [1:0] r;
    int n;
    axi_wr(`REG_ADDR, {22'h0, a}, r);
    axi_wr(`REG_WDATA, {16'h0, d}, r);
    axi_wr(`REG_CMD, {28'h0, cmd}, r);
    for (n = 0; n < 50; n++) begin
      axi_rd(`REG_STATUS, st, r);
      if (st[`ST_DONE] || st[`ST_REFUSED]) break;
    end
    if (n == 50) begin error_cnt++; give_verdict(); end
    axi_rd(`REG_RDATA, rd, r);
    axi_wr(`REG_STATUS, 32'h6, r);
  endtask : host_op

  task wait_req(input logic v);
    int n;
    for (n = 0; n < 20 && sock.host_request_n !== v; n++) @(posedge clk);
    `CHK(sock.host_request_n, v)
    if (n == 20 && sock.host_request_n !== v) give_verdict();
  endtask : wait_req

  task s_axi_err();
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(8'h40, d, r);
    `CHK(r, `RESP_SLVERR)
    `CHK(d, 32'h0)
    axi_wr(8'h40, 32'h1, r);
    `CHK(r, `RESP_SLVERR)
  endtask : s_axi_err

  // I/O cycles before I/O mode must leave the core untouched and get no acknowledge.
  task s_io_gate();
    logic [31:0] st, rd;
    logic [1:0]  r;
    int          c;
    axi_wr(`REG_CTRL, 32'h0, r);
    host_op(10'h004, 16'h0, {2'b11, `CMD_IORD}, st, rd);
    `CHK(st[`ST_REFUSED], 1'b1)
    axi_wr(`REG_CTRL, 32'h1, r);
    c = req_cnt;
    host_op(10'h004, 16'h0, {2'b11, `CMD_IORD}, st, rd);
    `CHK(req_cnt, c)
    `CHK(rd[15:0], 16'hffff)
    `CHK(st[`ST_ACK], 1'b0)
  endtask : s_io_gate

  // Word write with upper address bits set, then read back through the same register.
  task s_io_word();
    logic [31:0] st, rd;
    host_op(10'h3c6, 16'ha55a, {2'b11, `CMD_IOWR}, st, rd);
    `CHK(cap_addr, 9'h006)
    `CHK({cap_be, cap_we, cap_attr}, 4'b1110)
    `CHK(cap_wdata, 16'ha55a)
    host_op(10'h006, 16'h0, {2'b11, `CMD_IORD}, st, rd);
    `CHK(rd[15:0], 16'ha55a)
    `CHK(st[`ST_ACK], 1'b1)
  endtask : s_io_word

  // Low enable alone at even and odd address, high enable alone, both enables; only word reads are acknowledged.
  task s_lanes();
    logic [31:0] st, rd;
    logic [7:0]  ln, be;
    int          i;
    ln = 8'b11_10_01_01;
    be = 8'b11_10_10_01;
    for (i = 0; i < 4; i++) begin
      host_op({9'h008, i == 1}, 16'h0, {ln[2*i+:2], `CMD_IORD}, st, rd);
      `CHK(cap_be, be[2*i+:2])
      `CHK(cap_addr, 9'h010)
      `CHK(st[`ST_ACK], i == 3)
    end
  endtask : s_lanes

  task s_attr();
    logic [31:0] st, rd;
    int          c;
    host_op(10'h2a4, 16'h00c3, {2'b01, `CMD_ATWR}, st, rd);
    `CHK({cap_attr, cap_we, cap_be}, 4'b1101)
    `CHK(cap_addr, 9'h152)
    host_op(10'h2a4, 16'h0, {2'b01, `CMD_ATRD}, st, rd);
    `CHK(rd[7:0], 8'hc3)
    c = req_cnt;
    host_op(10'h2a5, 16'h0, {2'b01, `CMD_ATRD}, st, rd);
    `CHK(st[`ST_REFUSED], 1'b1)
    `CHK(req_cnt, c)
  endtask : s_attr

  // A non-default mask compares the upper address bits against the match value.
  task s_mask();
    logic [31:0] st, rd;
    int          c;
    mask <= 4'hf;
    match <= 4'h5;
    c = req_cnt;
    host_op({4'h5, 6'h08}, 16'h1234, {2'b11, `CMD_IOWR}, st, rd);
    `CHK(req_cnt, c + 1)
    host_op({4'h3, 6'h08}, 16'h1234, {2'b11, `CMD_IOWR}, st, rd);
    `CHK(req_cnt, c + 1)
    mask <= 4'h0;
  endtask : s_mask

  // Reset for two cycles, then each scenario in turn.
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    s_axi_err();
    wait_req(1'b0);
    cis_ready <= 1'b1;
    wait_req(1'b1);
    s_io_gate();
    io_mode <= 1'b1;
    irq <= 1'b1;
    wait_req(1'b0);
    irq <= 1'b0;
    wait_req(1'b1);
    s_io_word();
    s_lanes();
    s_attr();
    s_mask();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
